// *** core/rrs_framer.sv ***
// Requester request sideband capture, abort tracking and steering insertion
`timescale 1ns/100ps
module rrs_framer
  import rrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_req_stream_valid,
  input wire logic i_req_stream_last,
  input wire logic [RRS_SB_W-1:0] i_req_stream_sideband,
  input wire logic [RRS_STEER_W-1:0] i_steer_value,
  input wire logic i_link_ready,
  input wire logic i_tbl_wr_en,
  input wire logic [RRS_TBL_IDX_W-1:0] i_tbl_wr_idx,
  input wire logic [RRS_STEER_W-1:0] i_tbl_wr_value,
  output logic o_req_stream_ready,
  output logic o_beat,
  output logic o_first_beat,
  output rrs_hdr_t o_hdr,
  output logic o_hdr_valid,
  output logic o_abort,
  output logic o_nullify
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rrs_state_t fsm;
    rrs_hdr_t hdr;
    logic hdr_valid;
    logic abort_held;
    logic nullify;
  } rrs_st_t;

  rrs_st_t st;
  rrs_st_t next_st;
  logic beat;
  logic first;
  logic abort_now;
  logic [RRS_STEER_W-1:0] tbl_value;
  rrs_hdr_t cap;

  rrs_steer_table u_tbl (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr_en(i_tbl_wr_en),
    .i_wr_idx(i_tbl_wr_idx),
    .i_wr_value(i_tbl_wr_value),
    .i_rd_idx(i_steer_value[RRS_TBL_IDX_W-1:0]),
    .o_rd_value(tbl_value)
  );

  assign o_req_stream_ready = i_link_ready;
  assign beat = i_req_stream_valid & o_req_stream_ready;
  assign first = beat & (st.fsm == RRS_IDLE);
  // Abort ignored on the first beat
  assign abort_now = beat & !first & i_req_stream_sideband[RRS_ABORT_BIT];

  // ---------------------------------------------------------------
  // Field capture
  // ---------------------------------------------------------------
  always_comb begin
    cap.head_dword_byte_mask = i_req_stream_sideband[RRS_HEAD_LSB +: 4];
    cap.tail_dword_byte_mask = i_req_stream_sideband[RRS_TAIL_LSB +: 4];
    cap.payload_offset = i_req_stream_sideband[RRS_OFS_LSB +: 3];
    cap.hint_present = i_req_stream_sideband[RRS_HINT_BIT];
    cap.hint_type = i_req_stream_sideband[RRS_HTYPE_LSB +: 2];
    if (i_req_stream_sideband[RRS_INDIR_BIT]) begin
      cap.steer_value = tbl_value;
    end else begin
      cap.steer_value = i_steer_value;
    end
  end

  // ---------------------------------------------------------------
  // Packet tracking
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.nullify = 1'b0;
    if (first) begin
      next_st.hdr = cap;
      next_st.hdr_valid = 1'b1;
      next_st.abort_held = 1'b0;
    end
    if (abort_now) begin
      next_st.abort_held = 1'b1;
    end
    unique case (st.fsm)
      RRS_IDLE: begin
        if (beat && !i_req_stream_last) begin
          next_st.fsm = RRS_BODY;
        end
      end
      RRS_BODY: begin
        if (beat && i_req_stream_last) begin
          next_st.fsm = RRS_IDLE;
        end
      end
      default: begin
        next_st.fsm = RRS_IDLE;
      end
    endcase
    if (beat && i_req_stream_last) begin
      next_st.nullify = st.abort_held | abort_now;
      next_st.abort_held = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st.fsm <= RRS_IDLE;
      st.hdr <= '{
        head_dword_byte_mask: RRS_MASK_RST,
        tail_dword_byte_mask: RRS_MASK_RST,
        payload_offset: RRS_OFS_RST,
        hint_present: 1'b0,
        hint_type: RRS_HTYPE_RST,
        steer_value: RRS_STEER_RST
      };
      st.hdr_valid <= 1'b0;
      st.abort_held <= 1'b0;
      st.nullify <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_beat = beat;
  assign o_first_beat = first;
  assign o_hdr = st.hdr;
  assign o_hdr_valid = st.hdr_valid;
  assign o_abort = st.abort_held;
  assign o_nullify = st.nullify;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_first_capture;
    first;
  endsequence

  a_first_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_first_capture |=> (o_hdr.head_dword_byte_mask == $past(i_req_stream_sideband[RRS_HEAD_LSB +: 4]))
      && (o_hdr.tail_dword_byte_mask == $past(i_req_stream_sideband[RRS_TAIL_LSB +: 4])))
    else $error("header masks not captured on first beat");

  a_offset_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    first |=> o_hdr.payload_offset == $past(i_req_stream_sideband[RRS_OFS_LSB +: 3]))
    else $error("payload offset not captured");

  a_hint_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    first |=> o_hdr.hint_present == $past(i_req_stream_sideband[RRS_HINT_BIT])
      && o_hdr.hint_type == $past(i_req_stream_sideband[RRS_HTYPE_LSB +: 2]))
    else $error("hint fields not captured");

  a_hdr_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (beat && !first) |=> $stable(o_hdr))
    else $error("header changed on a later beat");

  a_direct_steer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (first && !i_req_stream_sideband[RRS_INDIR_BIT]) |=> o_hdr.steer_value == $past(i_steer_value))
    else $error("direct steering value altered");

  a_indirect_steer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (first && i_req_stream_sideband[RRS_INDIR_BIT]) |=> o_hdr.steer_value == $past(tbl_value))
    else $error("indirect steering value not from table");

  a_abort_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (abort_now && !i_req_stream_last) |=> o_abort throughout (!beat || !i_req_stream_last) [*1])
    else $error("abort not held after indication");

  a_abort_nullify: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (beat && i_req_stream_last && (o_abort || abort_now)) |=> o_nullify ##1 !o_nullify)
    else $error("aborted packet not nullified");

  a_first_no_abort: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (first && i_req_stream_last) |=> !o_nullify)
    else $error("first-beat abort took effect");

  sequence s_packet_end;
    beat && i_req_stream_last;
  endsequence

  a_abort_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_packet_end |=> !o_abort)
    else $error("abort leaked past the end of its packet");

  a_first_abort_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (first && !i_req_stream_last) |=> !o_abort)
    else $error("abort taken on the first beat");

  a_abort_at_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    first |-> !o_abort)
    else $error("abort carried into a new packet");

  a_nullify_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_nullify |-> $past(beat) && $past(i_req_stream_last))
    else $error("nullify without a packet end");

  a_nullify_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_nullify |=> !o_nullify)
    else $error("nullify longer than one cycle");

  a_ready_pass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_req_stream_ready == i_link_ready)
    else $error("ready does not follow the link");

  a_valid_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_hdr_valid |=> o_hdr_valid)
    else $error("header valid dropped without reset");

endmodule : rrs_framer

// *** core/rrs_pkg.sv ***
// Package for the request sideband framer: field layout, widths, states
package rrs_pkg;

  // ---------------------------------------------------------------
  // Sideband field layout
  // ---------------------------------------------------------------
  localparam int RRS_SB_W = 16;
  localparam int RRS_HEAD_LSB = 0;
  localparam int RRS_TAIL_LSB = 4;
  localparam int RRS_OFS_LSB = 8;
  localparam int RRS_ABORT_BIT = 11;
  localparam int RRS_HINT_BIT = 12;
  localparam int RRS_HTYPE_LSB = 13;
  localparam int RRS_INDIR_BIT = 15;
  localparam int RRS_STEER_W = 8;
  localparam int RRS_TBL_IDX_W = 4;
  localparam int RRS_TBL_DEPTH = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RRS_MASK_RST = 4'h0;
  localparam logic [2:0] RRS_OFS_RST = 3'h0;
  localparam logic [1:0] RRS_HTYPE_RST = 2'h0;
  localparam logic [7:0] RRS_STEER_RST = 8'h00;

  // Captured per-packet header
  typedef struct packed {
    logic [3:0] head_dword_byte_mask;
    logic [3:0] tail_dword_byte_mask;
    logic [2:0] payload_offset;
    logic hint_present;
    logic [1:0] hint_type;
    logic [7:0] steer_value;
  } rrs_hdr_t;

  typedef enum logic [1:0] {
    RRS_IDLE = 2'b01,
    RRS_BODY = 2'b10
  } rrs_state_t;

endpackage : rrs_pkg

// *** core/rrs_steer_table.sv ***
// Steering value table: software write port, combinational lookup
`timescale 1ns/100ps
module rrs_steer_table
  import rrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic [RRS_TBL_IDX_W-1:0] i_wr_idx,
  input wire logic [RRS_STEER_W-1:0] i_wr_value,
  input wire logic [RRS_TBL_IDX_W-1:0] i_rd_idx,
  output logic [RRS_STEER_W-1:0] o_rd_value
);

  typedef struct packed {
    logic [RRS_TBL_DEPTH-1:0][RRS_STEER_W-1:0] entry;
  } rrs_tbl_t;

  rrs_tbl_t st;
  rrs_tbl_t next_st;

  always_comb begin
    next_st = st;
    if (i_wr_en) begin
      next_st.entry[i_wr_idx] = i_wr_value;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rd_value = st.entry[i_rd_idx];

endmodule : rrs_steer_table

// *** sim/rrs_user_model.sv ***
// User application model: issues request packets beat by beat
`timescale 1ns/100ps
module rrs_user_model
  import rrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [RRS_SB_W-1:0] i_sb,
  input wire logic [RRS_STEER_W-1:0] i_steer,
  input wire logic [3:0] i_beats,
  input wire logic [3:0] i_ab,
  input wire logic i_ready,
  output logic o_valid,
  output logic o_last,
  output logic [RRS_SB_W-1:0] o_sb,
  output logic [RRS_STEER_W-1:0] o_steer
);
  logic [3:0] n;
  // ---------------------------------------------------------------
  // Packet sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_last <= 1'b0;
      o_sb <= 16'h0000;
      o_steer <= 8'h00;
      n <= 4'h0;
    end else if (i_go && !o_valid) begin
      // Header fields as given by the scenario
      o_valid <= 1'b1;
      n <= 4'h0;
      o_last <= (i_beats == 4'h1);
      o_sb <= {i_sb[15:12], (i_ab == 4'h0), i_sb[10:0]};
      o_steer <= i_steer;
    end else if (o_valid && i_ready) begin // Holds while ready low
      if (o_last) begin
        // Released lines show inverted values
        o_valid <= 1'b0;
        o_sb <= ~o_sb;
        o_steer <= ~o_steer;
      end else begin
        // Abort only on one later beat, then dropped
        n <= n + 4'h1;
        o_last <= (n + 4'h2 == i_beats);
        o_sb <= {~o_sb[15:12], (n + 4'h1 == i_ab), ~o_sb[10:0]};
        o_steer <= ~o_steer;
      end
    end
  end
endmodule : rrs_user_model

// *** sim/test_requester_request_sideband.sv ***
// Testbench for the request sideband framer
`timescale 1ns/100ps
module test_requester_request_sideband
  import rrs_pkg::*;
;
  typedef struct packed {logic [15:0] sb; logic [7:0] st; logic [3:0] n; logic [3:0] ab; logic stl;} rrs_row_t;
  localparam rrs_row_t ROWS[8] = '{
    '{16'h000f, 8'h11, 4'h1, 4'hf, 1'b0}, '{16'h03f3, 8'h22, 4'h4, 4'hf, 1'b1},
    '{16'h1001, 8'h33, 4'h2, 4'hf, 1'b0}, '{16'h3002, 8'h44, 4'h1, 4'hf, 1'b1},
    '{16'h5104, 8'h55, 4'h3, 4'hf, 1'b0}, '{16'hf00f, 8'hc7, 4'h2, 4'hf, 1'b0},
    '{16'h00ff, 8'h66, 4'h4, 4'h1, 1'b0}, '{16'h00ff, 8'h77, 4'h3, 4'h2, 1'b0}};
  logic i_clk_sys = 0, i_rst_n = 0, go = 0, rdy = 0, wr = 0, stl = 0;
  logic [3:0] widx = 0, beats = 1, ab = 4'hf;
  logic [7:0] wval = 0, steer = 0, ust;
  logic [15:0] sb = 0, usb;
  logic valid, last, hv, nul, rr, bt, fb, abt;
  rrs_hdr_t hdr;
  int bad_count = 0, checked = 0, cyc = 0, nuls = 0, i, j;
  int abts = 0, fbs = 0, bts = 0, ja, jf, jb;
  rrs_user_model rrs_user_model_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(go), .i_sb(sb),
    .i_steer(steer), .i_beats(beats), .i_ab(ab), .i_ready(rdy), .o_valid(valid), .o_last(last),
    .o_sb(usb), .o_steer(ust));
  rrs_framer rrs_framer_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_stream_valid(valid),
    .i_req_stream_last(last), .i_req_stream_sideband(usb), .i_steer_value(ust), .i_link_ready(rdy),
    .i_tbl_wr_en(wr), .i_tbl_wr_idx(widx), .i_tbl_wr_value(wval), .o_req_stream_ready(rr),
    .o_beat(bt), .o_first_beat(fb), .o_hdr(hdr), .o_hdr_valid(hv), .o_abort(abt), .o_nullify(nul));
  initial forever #2 i_clk_sys = ~i_clk_sys;
  // ---------------------------------------------------------------
  // Checks and closing
  // ---------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task stop_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  function automatic rrs_hdr_t exp_hdr(logic [15:0] s, logic [7:0] t);
    exp_hdr = {s[3:0], s[7:4], s[10:8], s[12], s[14:13], s[15] ? {t[3:0], ~t[3:0]} : t};
  endfunction : exp_hdr
  // Ready pacing, pulse count, timeout
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    rdy <= stl ? cyc[0] : 1'b1;
    if (nul === 1'b1) nuls <= nuls + 1;
    if (abt === 1'b1) abts <= abts + 1;
    if (fb === 1'b1) fbs <= fbs + 1;
    if (bt === 1'b1) bts <= bts + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    chk(hv, 0);
    chk(hdr, 0);
    for (i = 0; i < 16; i++) begin
      @(posedge i_clk_sys);
      wr <= 1'b1;
      widx <= i[3:0];
      wval <= {i[3:0], ~i[3:0]};
    end
    @(posedge i_clk_sys);
    wr <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge i_clk_sys);
      j = nuls;
      ja = abts;
      jf = fbs;
      jb = bts;
      {sb, steer, beats, ab, stl} <= ROWS[i];
      go <= 1'b1;
      @(posedge i_clk_sys);
      go <= 1'b0;
      do begin
        @(posedge i_clk_sys);
        #1;
      end while (valid === 1'b1);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk(hdr, exp_hdr(ROWS[i].sb, ROWS[i].st));
      chk(hv, 1);
      chk(nuls - j, (ROWS[i].ab != 0 && ROWS[i].ab < ROWS[i].n));
      chk(abts - ja, (ROWS[i].ab != 0 && ROWS[i].ab < ROWS[i].n) ? ROWS[i].n - 1 - ROWS[i].ab : 0);
      chk(fbs - jf, 1);
      chk(bts - jb, ROWS[i].n);
      chk(rr, rdy);
    end
    // Reset in mid-packet while abort is held
    @(posedge i_clk_sys);
    {sb, steer, beats, ab, stl} <= {16'h00ff, 8'h12, 4'h4, 4'h1, 1'b0};
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    #1;
    chk(abt, 1);
    @(posedge i_clk_sys);
    #1;
    chk(hv, 0);
    chk(hdr, 0);
    chk(abt, 0);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Abort on the first beat is ignored
    @(posedge i_clk_sys);
    j = nuls;
    ja = abts;
    {sb, steer, beats, ab, stl} <= {16'h00ff, 8'h12, 4'h2, 4'h0, 1'b0};
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    #1;
    chk(nuls - j, 0);
    chk(abts - ja, 0);
    stop_test();
  end
endmodule : test_requester_request_sideband
